/* verilog/mpu_attr_pkg.sv */
package mpu_attr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_REGIONS = 8;
    localparam int ATTR_W = 13;

    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_REGION_SEL = 8'h04;
    localparam logic [7:0] OFS_REGION_ATTR = 8'h08;
    localparam logic [7:0] OFS_FAULT_STAT = 8'h0c;
    localparam logic [7:0] OFS_FAULT_ADDR = 8'h10;
    localparam logic [7:0] OFS_LAST_ATTR = 8'h14;

    // Region attribute word layout
    localparam int ATTR_EN_BIT = 0;
    localparam int ATTR_B_BIT = 1;
    localparam int ATTR_C_BIT = 2;
    localparam int ATTR_S_BIT = 3;
    localparam int ATTR_TYPE_EXT_LSB = 4;
    localparam int ATTR_PERM_LSB = 8;
    localparam int ATTR_NOEXEC_BIT = 12;

    // Control word layout
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_PRIVDEF_BIT = 1;

    // Fault status layout
    localparam int FS_IACC_BIT = 0;
    localparam int FS_DACC_BIT = 1;
    localparam int FS_ADDR_VALID_BIT = 7;

    // Last-access attribute readback layout
    localparam int LAST_TYPE_LSB = 0;
    localparam int LAST_SHARE_BIT = 4;
    localparam int LAST_INNER_LSB = 8;
    localparam int LAST_OUTER_LSB = 10;

    // Values after reset
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [2:0] REGION_SEL_RESET = 3'h0;
    localparam logic [ATTR_W-1:0] ATTR_RESET = 13'h0000;
    localparam logic [7:0] FAULT_STAT_RESET = 8'h00;
    localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;

    // Access permission codes
    localparam logic [2:0] PERM_NONE = 3'h0;
    localparam logic [2:0] PERM_PRIV_RW = 3'h1;
    localparam logic [2:0] PERM_USER_RO = 3'h2;
    localparam logic [2:0] PERM_FULL = 3'h3;
    localparam logic [2:0] PERM_RESERVED = 3'h4;
    localparam logic [2:0] PERM_PRIV_RO = 3'h5;
    localparam logic [2:0] PERM_RO = 3'h6;
    localparam logic [2:0] PERM_RO_ALT = 3'h7;

    // Cache policy codes
    localparam logic [1:0] POL_NONCACHE = 2'h0;
    localparam logic [1:0] POL_WB_RWA = 2'h1;
    localparam logic [1:0] POL_WT_NWA = 2'h2;
    localparam logic [1:0] POL_WB_NWA = 2'h3;

    typedef enum logic [3:0] {
        MEM_STRONG = 4'b0001,
        MEM_DEVICE = 4'b0010,
        MEM_NORMAL = 4'b0100,
        MEM_RESERVED = 4'b1000
    } mem_type_t;

endpackage : mpu_attr_pkg

/* verilog/attr_if.sv */
`timescale 1ns/1ps
interface attr_if;
    import mpu_attr_pkg::*;
    logic [2:0] type_extension_field;
    logic shareable_bit;
    logic cacheable_bit;
    logic bufferable_bit;
    mem_type_t mem_type;
    logic shareable;
    logic [1:0] inner_cache_policy;
    logic [1:0] outer_cache_policy;

    modport decoder (
        input type_extension_field, shareable_bit, cacheable_bit, bufferable_bit,
        output mem_type, shareable, inner_cache_policy, outer_cache_policy
    );
    modport user (
        output type_extension_field, shareable_bit, cacheable_bit, bufferable_bit,
        input mem_type, shareable, inner_cache_policy, outer_cache_policy
    );
endinterface : attr_if

/* verilog/attr_decode.sv */
`timescale 1ns/1ps
module attr_decode
    import mpu_attr_pkg::*;
(
    attr_if.decoder a // Raw attribute bits in, decoded attributes out
);

    logic [1:0] cb;
    assign cb = {a.cacheable_bit, a.bufferable_bit};

    always_comb begin
        a.mem_type = MEM_RESERVED;
        a.shareable = 1'b0;
        a.inner_cache_policy = POL_NONCACHE;
        a.outer_cache_policy = POL_NONCACHE;
        if (a.type_extension_field[2]) begin
            // RULE11: cached normal memory
            a.mem_type = MEM_NORMAL;
            a.shareable = a.shareable_bit;
            // RULE12: two-bit policy codes pass through
            a.outer_cache_policy = a.type_extension_field[1:0];
            a.inner_cache_policy = cb;
        end else begin
            case (a.type_extension_field[1:0])
                2'b00: begin
                    if (!a.cacheable_bit) begin
                        // RULE7: ordered or device, always shared
                        // RULE8: shareable bit not looked at
                        a.mem_type = a.bufferable_bit ? MEM_DEVICE : MEM_STRONG;
                        a.shareable = 1'b1;
                    end else begin
                        // RULE9: normal write-through or write-back
                        a.mem_type = MEM_NORMAL;
                        a.shareable = a.shareable_bit;
                        a.inner_cache_policy = a.bufferable_bit ? POL_WB_NWA : POL_WT_NWA;
                        a.outer_cache_policy = a.bufferable_bit ? POL_WB_NWA : POL_WT_NWA;
                    end
                end
                2'b01: begin
                    // RULE10: noncacheable or write-back allocate
                    if (cb == 2'b00 || cb == 2'b11) begin
                        a.mem_type = MEM_NORMAL;
                        a.shareable = a.shareable_bit;
                        a.inner_cache_policy = (cb == 2'b11) ? POL_WB_RWA : POL_NONCACHE;
                        a.outer_cache_policy = (cb == 2'b11) ? POL_WB_RWA : POL_NONCACHE;
                    end
                end
                2'b10: begin
                    // RULE7: non-shared device, rest reserved
                    if (cb == 2'b00) begin
                        a.mem_type = MEM_DEVICE;
                    end
                end
                default: begin
                    a.mem_type = MEM_RESERVED;
                end
            endcase
        end
    end

endmodule : attr_decode

/* verilog/mpu_region_attribute_check.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE1: Fault any access not granted by permissions
// RULE2: Code 000 refuses every access
// RULE3: 001 privileged only, 011 full access
// RULE4: 010 user reads allowed, user writes fault
// RULE5: 101 allows privileged reads only
// RULE6: 110/111 read-only; 100 reserved
// RULE7: Ordered and device encodings from bufferable bit
// RULE8: Shareable bit ignored for ordered/device/reserved
// RULE9: Type ext 000 cacheable gives normal memory
// RULE10: Type ext 001 noncacheable or write-back allocate
// RULE11: Type ext top bit gives outer/inner policies
// RULE12: Two-bit cache policy code meanings
// RULE13: Policies reported only, never change behaviour
// RULE14: Software marks flash and internal SRAM
// RULE15: Software marks external SRAM and peripherals
// RULE16: Violation raises memory management fault
// RULE17: Fault cause recorded in status register
// RULE18: Highest numbered matching region wins
// RULE19: Checked same cycle, faulting access blocked
module mpu_region_attribute_check
    import mpu_attr_pkg::*;
#(
    parameter int REGIONS = NUM_REGIONS
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic [DATA_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic acc_valid, // Access presented
    input wire logic [31:0] acc_addr, // Access address
    input wire logic acc_write, // Access is a write
    input wire logic acc_fetch, // Access is an instruction fetch
    input wire logic acc_priv, // Access is privileged
    input wire logic [REGIONS-1:0] acc_hit, // Per-region address match
    output logic mem_valid, // Granted access towards memory
    output logic [31:0] mem_addr, // Granted address
    output logic mem_write, // Granted access is a write
    output mem_type_t mem_type, // Decoded memory type
    output logic mem_shareable, // Decoded shareability
    output logic [1:0] mem_inner_policy, // Decoded inner policy
    output logic [1:0] mem_outer_policy, // Decoded outer policy
    output logic perm_fault, // Permission fault pulse
    output logic mm_fault // Fault exception pending
);

    localparam int IDX_W = $clog2(REGIONS);

    logic [1:0] ctrl;
    logic [IDX_W-1:0] region_sel;
    logic [ATTR_W-1:0] region_attr [REGIONS];
    logic [7:0] fault_stat;
    logic [31:0] fault_addr;
    logic [15:0] last_attr;

    // Register decode
    wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    wire wr_sel = reg_wr && (reg_addr == OFS_REGION_SEL);
    wire wr_attr = reg_wr && (reg_addr == OFS_REGION_ATTR);
    wire wr_fstat = reg_wr && (reg_addr == OFS_FAULT_STAT);
    wire wr_faddr = reg_wr && (reg_addr == OFS_FAULT_ADDR);
    wire mpu_on = ctrl[CTRL_ENABLE_BIT];
    wire privdef = ctrl[CTRL_PRIVDEF_BIT];

    // Permission table for one access
    function automatic logic perm_ok(input logic [2:0] perm, input logic priv,
                                     input logic write);
        logic ok;
        ok = 1'b0;
        case (perm)
            // RULE2: no access at all
            PERM_NONE: ok = 1'b0;
            // RULE3: privileged read/write only
            PERM_PRIV_RW: ok = priv;
            // RULE4: user read only
            PERM_USER_RO: ok = priv || !write;
            // RULE3: full access
            PERM_FULL: ok = 1'b1;
            // RULE5: privileged read only
            PERM_PRIV_RO: ok = priv && !write;
            // RULE6: read-only for both levels
            PERM_RO, PERM_RO_ALT: ok = !write;
            // RULE6: reserved code treated as no access
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : perm_ok

    // Highest numbered enabled region that matches
    function automatic logic [IDX_W:0] pick_region(input logic [REGIONS-1:0] hits);
        logic [IDX_W:0] res;
        res = '0;
        for (int i = 0; i < REGIONS; i++) begin
            if (hits[i]) begin
                res = {1'b1, IDX_W'(i)};
            end
        end
        return res;
    endfunction : pick_region

    logic [REGIONS-1:0] live_hit;
    genvar g;
    generate
        for (g = 0; g < REGIONS; g++) begin : g_live
            assign live_hit[g] = acc_hit[g] && region_attr[g][ATTR_EN_BIT];
        end
    endgenerate

    // RULE18: highest region number takes precedence
    wire [IDX_W:0] pick = pick_region(live_hit);
    wire win_found = pick[IDX_W];
    wire [IDX_W-1:0] win_idx = pick[IDX_W-1:0];
    wire [ATTR_W-1:0] win_attr = region_attr[win_idx];
    wire [2:0] win_perm = win_attr[ATTR_PERM_LSB +: 3];
    wire win_noexec = win_attr[ATTR_NOEXEC_BIT];

    attr_if dec_if ();
    assign dec_if.type_extension_field = win_attr[ATTR_TYPE_EXT_LSB +: 3];
    assign dec_if.shareable_bit = win_attr[ATTR_S_BIT];
    assign dec_if.cacheable_bit = win_attr[ATTR_C_BIT];
    assign dec_if.bufferable_bit = win_attr[ATTR_B_BIT];

    attr_decode u_decode (
        .a(dec_if)
    );

    // RULE1: permission check against winning region
    // RULE19: evaluated in the cycle the access is presented
    wire region_ok = perm_ok(win_perm, acc_priv, acc_write) && !(acc_fetch && win_noexec);
    wire background_ok = acc_priv && privdef;
    wire access_ok = !mpu_on || (win_found ? region_ok : background_ok);
    wire grant = acc_valid && access_ok;
    wire fault = acc_valid && !access_ok;

    // Unmatched or disabled accesses carry a plain normal attribute
    wire use_decoded = mpu_on && win_found;
    wire mem_type_t next_type = use_decoded ? dec_if.mem_type : MEM_NORMAL;
    wire next_share = use_decoded ? dec_if.shareable : 1'b0;
    wire [1:0] next_inner = use_decoded ? dec_if.inner_cache_policy : POL_NONCACHE;
    wire [1:0] next_outer = use_decoded ? dec_if.outer_cache_policy : POL_NONCACHE;

    // Set terms win over write-one-to-clear
    wire [7:0] fault_set = {fault && !acc_fetch, 5'h00, fault && !acc_fetch,
                            fault && acc_fetch};
    wire [7:0] fault_clr = wr_fstat ? reg_wdata[7:0] : 8'h00;
    wire [7:0] next_fault_stat = (fault_stat & ~fault_clr) | fault_set;
    wire capture_addr = fault && !acc_fetch;

    // Register read selection
    logic [DATA_W-1:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        if (reg_addr == OFS_CTRL) begin
            next_rdata = {30'h0, ctrl};
        end else if (reg_addr == OFS_REGION_SEL) begin
            next_rdata = {{(DATA_W-IDX_W){1'b0}}, region_sel};
        end else if (reg_addr == OFS_REGION_ATTR) begin
            next_rdata = {{(DATA_W-ATTR_W){1'b0}}, region_attr[region_sel]};
        end else if (reg_addr == OFS_FAULT_STAT) begin
            next_rdata = {24'h0, fault_stat};
        end else if (reg_addr == OFS_FAULT_ADDR) begin
            next_rdata = fault_addr;
        end else if (reg_addr == OFS_LAST_ATTR) begin
            next_rdata = {16'h0, last_attr};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            region_sel <= IDX_W'(REGION_SEL_RESET);
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata[1:0];
            end
            if (wr_sel) begin
                region_sel <= reg_wdata[IDX_W-1:0];
            end
        end
    end

    generate
        for (g = 0; g < REGIONS; g++) begin : g_attr
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    region_attr[g] <= ATTR_RESET;
                end else if (wr_attr && region_sel == IDX_W'(g)) begin
                    region_attr[g] <= reg_wdata[ATTR_W-1:0];
                end
            end
        end
    endgenerate

    // RULE17: fault cause kept for software, address for data faults only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_stat <= FAULT_STAT_RESET;
            fault_addr <= FAULT_ADDR_RESET;
        end else begin
            fault_stat <= next_fault_stat;
            if (capture_addr) begin
                fault_addr <= acc_addr;
            end else if (wr_faddr) begin
                fault_addr <= reg_wdata;
            end
        end
    end

    // RULE13: attributes only reported, never gate the access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_attr <= 16'h0000;
        end else if (grant) begin
            last_attr <= {4'h0, next_outer, next_inner, 3'h0, next_share, next_type};
        end
    end

    // RULE19: faulting access never reaches memory
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_valid <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_write <= 1'b0;
            mem_type <= MEM_NORMAL;
            mem_shareable <= 1'b0;
            mem_inner_policy <= POL_NONCACHE;
            mem_outer_policy <= POL_NONCACHE;
        end else begin
            mem_valid <= grant;
            mem_addr <= grant ? acc_addr : 32'h0000_0000;
            mem_write <= grant && acc_write;
            mem_type <= next_type;
            mem_shareable <= next_share;
            mem_inner_policy <= next_inner;
            mem_outer_policy <= next_outer;
        end
    end

    // RULE16: fault exception raised until status cleared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perm_fault <= 1'b0;
            mm_fault <= 1'b0;
            reg_rdata <= '0;
        end else begin
            perm_fault <= fault;
            mm_fault <= |next_fault_stat[FS_DACC_BIT:FS_IACC_BIT];
            reg_rdata <= reg_rd ? next_rdata : '0;
        end
    end

endmodule : mpu_region_attribute_check

/* dv/mpu_chk.sv */
`timescale 1ns/1ps
module mpu_chk
    import mpu_attr_pkg::*;
#(
    parameter int REGIONS = NUM_REGIONS
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic acc_valid, // Access
    input wire logic [31:0] acc_addr, // Access address
    input wire logic acc_write, // Access write
    input wire logic [REGIONS-1:0] acc_hit, // Matches
    input wire logic mem_valid, // Grant
    input wire logic [31:0] mem_addr, // Granted address
    input wire logic mem_write, // Granted write
    input wire mem_type_t mem_type, // Type
    input wire logic mem_shareable, // Shareable
    input wire logic [1:0] mem_inner_policy, // Inner
    input wire logic [1:0] mem_outer_policy, // Outer
    input wire logic perm_fault, // Fault pulse
    input wire logic mm_fault // Fault pending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_answer; acc_valid |=> mem_valid != perm_fault; endproperty
    property p_idle; !acc_valid |=> !mem_valid && !perm_fault; endproperty
    property p_pend; perm_fault |-> mm_fault; endproperty
    property p_addr; mem_valid |-> mem_addr == $past(acc_addr); endproperty
    property p_write; mem_write |-> mem_valid && $past(acc_write); endproperty
    property p_block; perm_fault |-> !mem_write && mem_addr == 32'h0; endproperty
    property p_strong; mem_type == MEM_STRONG |-> mem_shareable; endproperty
    property p_rsvd;
        mem_type == MEM_RESERVED |-> !mem_shareable && mem_inner_policy == 2'h0
            && mem_outer_policy == 2'h0;
    endproperty
    a_answer: assert property (p_answer)
        else $error("access without exactly one answer");
    a_idle: assert property (p_idle)
        else $error("answer without access");
    a_pend: assert property (p_pend)
        else $error("fault not pending");
    a_addr: assert property (p_addr)
        else $error("granted address wrong");
    a_write: assert property (p_write)
        else $error("granted direction wrong");
    a_block: assert property (p_block)
        else $error("faulting access leaked");
    a_strong: assert property (p_strong)
        else $error("ordered memory not shareable");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved encoding attributes");
    c_fault: cover property (perm_fault);
    c_dev: cover property (mem_valid && mem_type == MEM_DEVICE);
    c_overlap: cover property (acc_valid && $countones(acc_hit) > 1);
endmodule : mpu_chk

bind mpu_region_attribute_check mpu_chk #(.REGIONS(REGIONS)) u_chk (.clk(clk),
    .rst_n(rst_n), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_hit(acc_hit), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_write(mem_write),
    .mem_type(mem_type), .mem_shareable(mem_shareable), .mem_inner_policy(mem_inner_policy),
    .mem_outer_policy(mem_outer_policy), .perm_fault(perm_fault), .mm_fault(mm_fault));

/* dv/cpu_model.sv */
`timescale 1ns/1ps
module cpu_model (
    input wire logic clk, // Clock
    output logic acc_valid, // Access
    output logic [31:0] acc_addr, // Address
    output logic acc_write, // Write
    output logic acc_fetch, // Fetch
    output logic acc_priv, // Privileged
    output logic [7:0] acc_hit // Matches
);
    initial begin
        acc_valid = 1'b0;
        {acc_addr, acc_write, acc_fetch, acc_priv, acc_hit} = '0;
    end
    task automatic issue(input logic [31:0] a, input logic w, f, p,
                         input logic [7:0] h, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        acc_valid <= 1'b1;
        {acc_addr, acc_write, acc_fetch, acc_priv, acc_hit} <= {a, w, f, p, h};
        @(posedge clk);
        acc_valid <= 1'b0;
        // Scrambled when idle so stale qualifiers are never trusted
        {acc_addr, acc_write, acc_fetch, acc_priv, acc_hit} <= ~{a, w, f, p, h};
    endtask : issue
endmodule : cpu_model

/* dv/mpu_region_attribute_check_tb.sv */
`timescale 1ns/1ps
module mpu_region_attribute_check_tb;
    import mpu_attr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, acc_addr, mem_addr, rv;
    logic acc_valid, acc_write, acc_fetch, acc_priv, mem_valid, mem_write;
    logic mem_shareable, perm_fault, mm_fault;
    logic [7:0] acc_hit;
    logic [1:0] mem_inner_policy, mem_outer_policy;
    mem_type_t mem_type;
    int miscompares = 0;
    int cmp_count = 0;
    logic [5:0] q[$];
    logic [8:0] e;
    always #20 clk = ~clk;
    mpu_region_attribute_check #(.REGIONS(8)) DUT (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_write(acc_write), .acc_fetch(acc_fetch), .acc_priv(acc_priv), .acc_hit(acc_hit),
        .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_write(mem_write),
        .mem_type(mem_type), .mem_shareable(mem_shareable),
        .mem_inner_policy(mem_inner_policy), .mem_outer_policy(mem_outer_policy),
        .perm_fault(perm_fault), .mm_fault(mm_fault));
    cpu_model u_cpu (.clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_write(acc_write), .acc_fetch(acc_fetch), .acc_priv(acc_priv), .acc_hit(acc_hit));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    function automatic logic ok_model(input logic [2:0] perm, input logic p, w);
        case (perm)
            3'h1: return p;
            3'h2: return p || !w;
            3'h3: return 1'b1;
            3'h5: return p && !w;
            3'h6, 3'h7: return !w;
            default: return 1'b0;
        endcase
    endfunction : ok_model
    function automatic logic [8:0] attr_model(input logic [5:0] v);
        logic [2:0] t;
        logic s, c, b;
        {t, s, c, b} = v;
        if (t[2]) return {MEM_NORMAL, s, c, b, t[1:0]};
        if (t == 3'h0 && !c) return {b ? MEM_DEVICE : MEM_STRONG, 5'h10};
        if (t == 3'h0) return {MEM_NORMAL, s, b ? 4'hf : 4'ha};
        if (t == 3'h1 && c == b) return {MEM_NORMAL, s, c ? 4'h5 : 4'h0};
        if (t == 3'h2 && !c && !b) return {MEM_DEVICE, 5'h00};
        return {MEM_RESERVED, 5'h00};
    endfunction : attr_model
    // Expect 9'h1ff to skip attribute comparison
    task automatic acc(input logic w, f, p, input logic [7:0] h, input logic ok,
                       input logic [8:0] x, input int gap);
        logic [31:0] a;
        a = $urandom;
        u_cpu.issue(a, w, f, p, h, gap);
        #1;
        chk("grant", {mem_valid, perm_fault}, {ok, !ok});
        chk("addr", mem_addr, ok ? a : 32'h0);
        chk("write", mem_write, ok && w);
        if (ok && x != 9'h1ff)
            chk("attr", {mem_type, mem_shareable, mem_inner_policy, mem_outer_policy}, x);
        if (!ok) begin
            rd(OFS_FAULT_STAT);
            chk("status", rv, f ? 32'h1 : 32'h82);
            chk("pending", mm_fault, 1'b1);
            rd(OFS_FAULT_ADDR);
            if (!f) chk("faddr", rv, a);
            wr(OFS_FAULT_STAT, 32'h83);
            rd(OFS_FAULT_STAT);
            chk("cleared", rv, 32'h0);
            chk("released", mm_fault, 1'b0);
        end
    endtask : acc
    task automatic final_report;
        $display("Checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        $display("Error watchdog expected finish seen timeout");
        final_report();
    end
    initial begin
        void'($urandom(42040));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL);
        chk("ctrl", rv, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rd(8'h3c);
        chk("unmapped", rv, 32'h0);
        wr(OFS_REGION_SEL, 32'h3);
        rd(OFS_REGION_ATTR);
        chk("attr_rst", rv, 32'h0);
        wr(OFS_REGION_ATTR, 32'h1fff);
        rd(OFS_REGION_ATTR);
        chk("attr_rw", rv, 32'h1fff);
        wr(OFS_REGION_ATTR, 32'h0);
        acc(1'b1, 1'b0, 1'b0, 8'hff, 1'b1, {MEM_NORMAL, 5'h0}, 0);
        $display("test registers and disabled done");
        wr(OFS_CTRL, 32'h1);
        wr(OFS_REGION_SEL, 32'h0);
        for (int perm = 0; perm < 8; perm++) begin
            wr(OFS_REGION_ATTR, {perm[2:0], 8'h05});
            for (int k = 0; k < 4; k++)
                acc(k[0], 1'b0, k[1], 8'h01, ok_model(perm[2:0], k[1], k[0]),
                    attr_model(6'h02), 0);
        end
        wr(OFS_REGION_ATTR, 32'h1305);
        acc(1'b0, 1'b1, 1'b1, 8'h01, 1'b0, 9'h1ff, 0);
        $display("test permissions done");
        wr(OFS_REGION_SEL, 32'h7);
        wr(OFS_REGION_ATTR, 32'h0005);
        acc(1'b0, 1'b0, 1'b1, 8'h81, 1'b0, 9'h1ff, 0);
        wr(OFS_REGION_ATTR, 32'h0004);
        // Region 7 disabled, so region 0 full access applies
        acc(1'b0, 1'b0, 1'b1, 8'h81, 1'b1, 9'h1ff, 0);
        acc(1'b0, 1'b0, 1'b1, 8'h00, 1'b0, 9'h1ff, 0);
        wr(OFS_CTRL, 32'h3);
        acc(1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 9'h1ff, 0);
        acc(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 9'h1ff, 0);
        $display("test overlap and background done");
        wr(OFS_REGION_SEL, 32'h0);
        // Flash, internal SRAM, external SRAM, peripherals
        q = {6'h02, 6'h06, 6'h07, 6'h05};
        for (int i = 0; i < 64; i++) q.push_back(i[5:0]);
        foreach (q[i]) begin
            e = attr_model(q[i]);
            wr(OFS_REGION_ATTR, {3'h3, 1'b0, q[i], 1'b1});
            acc($urandom_range(1), 1'b0, 1'b0, 8'h01, 1'b1, e, $urandom_range(2));
            rd(OFS_LAST_ATTR);
            chk("last", rv, {e[1:0], e[3:2], 3'h0, e[4], e[8:5]});
        end
        $display("test attribute decode done");
        final_report();
    end
endmodule : mpu_region_attribute_check_tb
